// >>> alu_core_pkg.sv
// Purpose: Constants and types for the ALU flag and operand address core.
// Assumes: One core clock, AHB-Lite register access, 32-bit word registers.
// Notes: Register offsets are byte addresses on the AHB-Lite slave.
`default_nettype none

package alu_core_pkg;

  // ==========================================================
  // Register map (AHB-Lite byte offsets)
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ACCUM = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_PTR0 = 8'h0C;
  localparam logic [7:0] OFS_PTR1 = 8'h10;
  localparam logic [7:0] OFS_PTR2 = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;

  // ==========================================================
  // Reset values
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [7:0] RST_ACCUM = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;

  // ==========================================================
  // Flag bit positions inside the implemented five bits
  localparam int FLAG_NEG = 4;
  localparam int FLAG_OVF = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_CARRY = 0;

  // ==========================================================
  // Data memory map points
  localparam logic [11:0] FLAGS_DATA_ADDR = 12'hFD8;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [1:0] INDEX_PTR = 2'h2;

  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    add_accum_file_op = 4'h0,
    add_literal_op = 4'h1,
    literal_minus_accum_op = 4'h2,
    file_minus_accum_op = 4'h3,
    rotate_left_op = 4'h4,
    rotate_right_op = 4'h5,
    register_clear_op = 4'h6,
    bit_clear_op = 4'h7,
    bit_set_op = 4'h8,
    nibble_swap_op = 4'h9,
    accum_to_file_op = 4'hA,
    file_to_file_move_op = 4'hB,
    and_accum_file_op = 4'hC,
    move_literal_op = 4'hD,
    jump_op = 4'hE,
    no_op = 4'hF
  } alu_op_t;

  // Operand addressing of the file operand
  typedef enum logic [2:0] {
    direct_mode = 3'h0,
    indirect_operand_alias = 3'h1,
    pointer_after_increment = 3'h2,
    pointer_after_decrement = 3'h3,
    pointer_before_increment = 3'h4,
    pointer_plus_accumulator = 3'h5
  } addr_mode_t;

endpackage : alu_core_pkg

`default_nettype wire

// >>> alu_core.sv
// Purpose: ALU condition flags, operand addressing and write-back steering.
// Assumes: The file operand arrives combinationally for data_addr.
// Notes: One commit per exec_valid cycle; zero-wait AHB-Lite, OKAY only.
`default_nettype none

module alu_core (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Instruction issue
  input wire logic exec_valid,
  input wire logic [3:0] exec_op,
  input wire logic [2:0] exec_mode,
  input wire logic [1:0] ptr_sel,
  input wire logic [7:0] file_addr,
  input wire logic access_sel,
  input wire logic dest_sel,
  input wire logic [7:0] literal,
  input wire logic [2:0] bit_sel,
  input wire logic [11:0] full_src_addr,
  input wire logic [11:0] full_dst_addr,
  input wire logic [19:0] prog_target,
  input wire logic extended_isa_enable,
  // Data memory side
  output logic [11:0] data_addr,
  input wire logic [7:0] file_data_in,
  output logic wb_valid,
  output logic [11:0] wb_addr,
  output logic [7:0] wb_data,
  output logic jump_valid,
  output logic [19:0] jump_target,
  output logic [7:0] accum_out,
  output logic [4:0] flags_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [4:0] flags;
    logic [7:0] acc;
    logic [3:0] bank;
    logic [2:0][11:0] ptr;
    logic wb_valid;
    logic [11:0] wb_addr;
    logic [7:0] wb_data;
    logic jump_valid;
    logic [19:0] jump_target;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  alu_core_pkg::alu_op_t op;
  alu_core_pkg::addr_mode_t mode;
  assign op = alu_core_pkg::alu_op_t'(exec_op);
  assign mode = alu_core_pkg::addr_mode_t'(exec_mode);

  // ==========================================================
  // Operand address forming
  logic [11:0] sel_ptr;
  logic [11:0] acc_offset;
  logic [11:0] ind_addr;
  logic [11:0] step_ptr;
  logic step_en;
  logic [11:0] dir_addr;
  logic indexed;

  always_comb begin
    sel_ptr = cur.ptr[ptr_sel];
    acc_offset = {{4{cur.acc[7]}}, cur.acc};
    case (mode)
      alu_core_pkg::pointer_before_increment: begin
        ind_addr = sel_ptr + 12'h001;
      end
      alu_core_pkg::pointer_plus_accumulator: begin
        ind_addr = sel_ptr + acc_offset;
      end
      default: begin
        ind_addr = sel_ptr;
      end
    endcase
    case (mode)
      alu_core_pkg::pointer_after_increment: begin
        step_ptr = sel_ptr + 12'h001;
        step_en = 1'b1;
      end
      alu_core_pkg::pointer_after_decrement: begin
        step_ptr = sel_ptr - 12'h001;
        step_en = 1'b1;
      end
      alu_core_pkg::pointer_before_increment: begin
        step_ptr = sel_ptr + 12'h001;
        step_en = 1'b1;
      end
      default: begin
        step_ptr = sel_ptr;
        step_en = 1'b0;
      end
    endcase
    indexed = extended_isa_enable && !access_sel &&
              (file_addr < alu_core_pkg::ACCESS_SPLIT);
    if (access_sel) begin
      dir_addr = {cur.bank, file_addr};
    end else if (indexed) begin
      dir_addr = cur.ptr[alu_core_pkg::INDEX_PTR] + {4'h0, file_addr};
    end else if (file_addr < alu_core_pkg::ACCESS_SPLIT) begin
      dir_addr = {alu_core_pkg::ACCESS_LOW_BANK, file_addr};
    end else begin
      dir_addr = {alu_core_pkg::ACCESS_HIGH_BANK, file_addr};
    end
    if (op == alu_core_pkg::file_to_file_move_op) begin
      data_addr = full_src_addr;
    end else if (mode == alu_core_pkg::direct_mode) begin
      data_addr = dir_addr;
    end else begin
      data_addr = ind_addr;
    end
  end

  // ==========================================================
  // Arithmetic and flags
  logic [7:0] opnd;
  logic [7:0] addend_a;
  logic [7:0] addend_b;
  logic add_cin;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] result;
  logic [4:0] calc_flags;
  logic affects;
  logic to_file;
  logic writes;
  logic [11:0] dst_addr;

  always_comb begin
    // Flag register reads back through the core itself
    opnd = (data_addr == alu_core_pkg::FLAGS_DATA_ADDR) ?
           {3'h0, cur.flags} : file_data_in;
    case (op)
      alu_core_pkg::add_literal_op: begin
        addend_a = cur.acc;
        addend_b = literal;
        add_cin = 1'b0;
      end
      alu_core_pkg::literal_minus_accum_op: begin
        addend_a = literal;
        addend_b = ~cur.acc;
        add_cin = 1'b1;
      end
      alu_core_pkg::file_minus_accum_op: begin
        addend_a = opnd;
        addend_b = ~cur.acc;
        add_cin = 1'b1;
      end
      default: begin
        addend_a = opnd;
        addend_b = cur.acc;
        add_cin = 1'b0;
      end
    endcase
    sum = {1'b0, addend_a} + {1'b0, addend_b} + {8'h00, add_cin};
    low_sum = {1'b0, addend_a[3:0]} + {1'b0, addend_b[3:0]} +
              {4'h0, add_cin};
    calc_flags = cur.flags;
    affects = 1'b0;
    to_file = dest_sel;
    writes = 1'b1;
    result = opnd;
    case (op)
      alu_core_pkg::add_accum_file_op,
      alu_core_pkg::add_literal_op,
      alu_core_pkg::literal_minus_accum_op,
      alu_core_pkg::file_minus_accum_op: begin
        result = sum[7:0];
        affects = 1'b1;
        calc_flags[alu_core_pkg::FLAG_HALF] = low_sum[4];
        calc_flags[alu_core_pkg::FLAG_CARRY] = sum[8];
        calc_flags[alu_core_pkg::FLAG_OVF] =
          (addend_a[7] == addend_b[7]) && (sum[7] != addend_a[7]);
        if (op == alu_core_pkg::add_literal_op ||
            op == alu_core_pkg::literal_minus_accum_op) begin
          to_file = 1'b0;
        end
      end
      alu_core_pkg::rotate_left_op: begin
        result = {opnd[6:0], cur.flags[alu_core_pkg::FLAG_CARRY]};
        affects = 1'b1;
        calc_flags[alu_core_pkg::FLAG_HALF] = opnd[3];
        calc_flags[alu_core_pkg::FLAG_CARRY] = opnd[7];
      end
      alu_core_pkg::rotate_right_op: begin
        result = {cur.flags[alu_core_pkg::FLAG_CARRY], opnd[7:1]};
        affects = 1'b1;
        calc_flags[alu_core_pkg::FLAG_HALF] = opnd[4];
        calc_flags[alu_core_pkg::FLAG_CARRY] = opnd[0];
      end
      alu_core_pkg::register_clear_op: begin
        result = 8'h00;
        affects = 1'b1;
        to_file = 1'b1;
      end
      alu_core_pkg::and_accum_file_op: begin
        result = opnd & cur.acc;
        affects = 1'b1;
      end
      alu_core_pkg::bit_clear_op: begin
        result = opnd & ~(8'h01 << bit_sel);
        to_file = 1'b1;
      end
      alu_core_pkg::bit_set_op: begin
        result = opnd | (8'h01 << bit_sel);
        to_file = 1'b1;
      end
      alu_core_pkg::nibble_swap_op: begin
        result = {opnd[3:0], opnd[7:4]};
      end
      alu_core_pkg::accum_to_file_op: begin
        result = cur.acc;
        to_file = 1'b1;
      end
      alu_core_pkg::file_to_file_move_op: begin
        to_file = 1'b1;
      end
      alu_core_pkg::move_literal_op: begin
        result = literal;
        to_file = 1'b0;
      end
      default: begin
        writes = 1'b0;
      end
    endcase
    if (affects) begin
      // negative from msb, clear keeps it
      if (op != alu_core_pkg::register_clear_op)
        calc_flags[alu_core_pkg::FLAG_NEG] = result[7];
      calc_flags[alu_core_pkg::FLAG_ZERO] = (result == 8'h00);
    end
    dst_addr = (op == alu_core_pkg::file_to_file_move_op) ?
               full_dst_addr : data_addr;
  end

  // ==========================================================
  // Commit and bus
  logic addr_phase;
  logic [7:0] ofs;
  assign addr_phase = hsel && htrans[1] && hready;
  assign ofs = haddr[7:0];

  always_comb begin
    next_cur = cur;
    next_cur.wb_valid = 1'b0;
    next_cur.jump_valid = 1'b0;
    next_cur.bus_wr = addr_phase && hwrite && (hsize == 3'h2);
    next_cur.bus_addr = ofs;
    // Bus writes land first; a committing instruction overrides them
    if (cur.bus_wr) begin
      case (cur.bus_addr)
        alu_core_pkg::OFS_FLAGS: next_cur.flags = hwdata[4:0];
        alu_core_pkg::OFS_ACCUM: next_cur.acc = hwdata[7:0];
        alu_core_pkg::OFS_BANK: next_cur.bank = hwdata[3:0];
        alu_core_pkg::OFS_PTR0: next_cur.ptr[0] = hwdata[11:0];
        alu_core_pkg::OFS_PTR1: next_cur.ptr[1] = hwdata[11:0];
        alu_core_pkg::OFS_PTR2: next_cur.ptr[2] = hwdata[11:0];
        default: ;
      endcase
    end
    if (exec_valid) begin
      if (mode != alu_core_pkg::direct_mode && step_en &&
          op != alu_core_pkg::file_to_file_move_op) begin
        next_cur.ptr[ptr_sel] = step_ptr;
      end
      next_cur.flags = calc_flags;
      if (op == alu_core_pkg::jump_op) begin
        next_cur.jump_valid = 1'b1;
        next_cur.jump_target = prog_target;
      end else if (writes && !to_file) begin
        next_cur.acc = result;
      end else if (writes) begin
        if (dst_addr == alu_core_pkg::FLAGS_DATA_ADDR) begin
          if (!affects) begin
            next_cur.flags = result[4:0];
          end
        end else begin
          next_cur.wb_valid = 1'b1;
          next_cur.wb_addr = dst_addr;
          next_cur.wb_data = result;
        end
      end
    end
    case (ofs)
      alu_core_pkg::OFS_FLAGS: next_cur.rdata = {27'h0, cur.flags};
      alu_core_pkg::OFS_ACCUM: next_cur.rdata = {24'h0, cur.acc};
      alu_core_pkg::OFS_BANK: next_cur.rdata = {28'h0, cur.bank};
      alu_core_pkg::OFS_PTR0: next_cur.rdata = {20'h0, cur.ptr[0]};
      alu_core_pkg::OFS_PTR1: next_cur.rdata = {20'h0, cur.ptr[1]};
      alu_core_pkg::OFS_PTR2: next_cur.rdata = {20'h0, cur.ptr[2]};
      alu_core_pkg::OFS_MODE: next_cur.rdata = {31'h0, extended_isa_enable};
      default: next_cur.rdata = 32'h0;
    endcase
    if (!(addr_phase && !hwrite)) begin
      next_cur.rdata = cur.rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
      cur.flags <= alu_core_pkg::RST_FLAGS;
      cur.acc <= alu_core_pkg::RST_ACCUM;
      cur.bank <= alu_core_pkg::RST_BANK;
      cur.ptr <= {3{alu_core_pkg::RST_PTR}};
    end else begin
      cur <= next_cur;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = cur.rdata;
  assign wb_valid = cur.wb_valid;
  assign wb_addr = cur.wb_addr;
  assign wb_data = cur.wb_data;
  assign jump_valid = cur.jump_valid;
  assign jump_target = cur.jump_target;
  assign accum_out = cur.acc;
  assign flags_out = cur.flags;

endmodule : alu_core

`default_nettype wire

// >>> alu_core_props.sv
// Purpose: Concurrent checks on the ALU flag and operand address core.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Bound to every alu_core instance at the foot of this file.
`default_nettype none

module alu_core_props (
  input wire logic hclk, hresetn, hsel, hwrite, hready,
  input wire logic [31:0] haddr, hrdata,
  input wire logic [1:0] htrans,
  input wire logic exec_valid, access_sel, dest_sel, wb_valid, jump_valid,
  input wire logic [3:0] exec_op,
  input wire logic [2:0] exec_mode,
  input wire logic [7:0] file_addr, literal, file_data_in, wb_data,
  input wire logic [7:0] accum_out,
  input wire logic [11:0] full_src_addr, full_dst_addr, data_addr, wb_addr,
  input wire logic [19:0] prog_target, jump_target,
  input wire logic [4:0] flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Reference sums of the literal ops
  logic [8:0] lsum;
  logic [8:0] ldif;
  logic [4:0] lhalf;
  assign lsum = {1'b0, literal} + {1'b0, accum_out};
  assign ldif = {1'b0, literal} + {1'b0, ~accum_out} + 9'h001;
  assign lhalf = {1'b0, literal[3:0]} + {1'b0, accum_out[3:0]};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Properties
  add_carries_a:
    assert property (exec_valid && exec_op == alu_core_pkg::add_literal_op
      |=> accum_out == $past(lsum[7:0]) && flags_out[0] == $past(lsum[8])
      && flags_out[1] == $past(lhalf[4]) && flags_out[3] ==
      $past(literal[7] == accum_out[7] && lsum[7] != literal[7]))
    else $error("add result or flags wrong");
  sub_borrow_a:
    assert property (exec_valid
      && exec_op == alu_core_pkg::literal_minus_accum_op
      |=> accum_out == $past(ldif[7:0]) && flags_out[0] == $past(ldif[8]))
    else $error("subtract result or borrow wrong");
  zero_neg_a:
    assert property (exec_valid && exec_op inside
      {alu_core_pkg::add_literal_op, alu_core_pkg::literal_minus_accum_op}
      |=> flags_out[2] == (accum_out == 8'h00)
      && flags_out[4] == accum_out[7])
    else $error("zero or negative flag wrong");
  rotate_left_a:
    assert property (exec_valid && exec_op == alu_core_pkg::rotate_left_op
      && !dest_sel && data_addr != alu_core_pkg::FLAGS_DATA_ADDR
      |=> accum_out == {$past(file_data_in[6:0]), $past(flags_out[0])}
      && flags_out[1:0] == {$past(file_data_in[3]), $past(file_data_in[7])})
    else $error("rotate left wrong");
  clear_flags_a:
    assert property (exec_valid && exec_op == alu_core_pkg::register_clear_op
      && data_addr == alu_core_pkg::FLAGS_DATA_ADDR
      |=> flags_out == ($past(flags_out) | 5'h04) && !wb_valid)
    else $error("clearing flags wrong");
  forced_bank_a:
    assert property (exec_valid && exec_mode == alu_core_pkg::direct_mode
      && !access_sel && file_addr >= 8'h60
      && exec_op != alu_core_pkg::file_to_file_move_op
      |-> data_addr == {4'hF, file_addr})
    else $error("access bank address wrong");
  full_move_a:
    assert property (exec_valid && exec_op == alu_core_pkg::file_to_file_move_op
      && full_dst_addr != alu_core_pkg::FLAGS_DATA_ADDR
      |-> data_addr == full_src_addr ##1 wb_valid
      && wb_addr == $past(full_dst_addr) && wb_data == $past(file_data_in))
    else $error("file to file move wrong");
  dest_file_a:
    assert property (exec_valid && exec_op == alu_core_pkg::add_accum_file_op
      && dest_sel && data_addr != alu_core_pkg::FLAGS_DATA_ADDR
      |=> wb_valid && wb_addr == $past(data_addr) && $stable(accum_out))
    else $error("file destination wrong");
  jump_target_a:
    assert property (exec_valid && exec_op == alu_core_pkg::jump_op
      |=> jump_valid && jump_target == $past(prog_target))
    else $error("jump target wrong");
  flags_upper_a:
    assert property (hsel && htrans[1] && hready && !hwrite
      && haddr == 32'h0000_0000 |=> hrdata[31:5] == 27'h0)
    else $error("flag upper bits not zero");
endmodule : alu_core_props

bind alu_core alu_core_props i_alu_core_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .haddr(haddr), .hrdata(hrdata), .htrans(htrans),
  .exec_valid(exec_valid), .access_sel(access_sel), .dest_sel(dest_sel),
  .wb_valid(wb_valid), .jump_valid(jump_valid), .exec_op(exec_op),
  .exec_mode(exec_mode), .file_addr(file_addr), .literal(literal),
  .file_data_in(file_data_in), .wb_data(wb_data), .accum_out(accum_out),
  .full_src_addr(full_src_addr), .full_dst_addr(full_dst_addr),
  .data_addr(data_addr), .wb_addr(wb_addr), .prog_target(prog_target),
  .jump_target(jump_target), .flags_out(flags_out));

`default_nettype wire

// >>> test_alu_core.sv
// Purpose: Self-checking bench for the ALU flag and address core.
// Assumes: Zero-wait AHB-Lite slave; the bench plays data memory.
// Notes: Drivers queue expectations; a monitor checks them in order.
`default_nettype none
`define CHK(g, e) begin ev = (e); gv = (g); num_checks++; \
  if (gv !== ev) begin errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, gv, ev); end end

module test_alu_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, exec_valid = 0;
  logic access_sel = 0, dest_sel = 0, extended_isa_enable = 0, rd_dp = 0;
  logic hready, hreadyout, hresp, wb_valid, jump_valid;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, ev, gv;
  logic [1:0] htrans = '0, ptr_sel = '0;
  logic [2:0] hsize = 3'h2, exec_mode = '0, bit_sel = '0;
  logic [3:0] exec_op = 4'hF;
  logic [7:0] file_addr = '0, literal = '0, file_data_in = '0, wb_data;
  logic [7:0] accum_out, a0, b0, sr = 8'h09;
  logic [11:0] full_src_addr = '0, full_dst_addr = '0, data_addr, wb_addr;
  logic [19:0] prog_target = '0, jump_target;
  logic [4:0] flags_out;
  logic [12:0] r;
  logic [23:0] t;
  int errors = 0, num_checks = 0;
  logic [31:0] exp_rd[$];
  logic [19:0] exp_wb[$], exp_j[$];
  alu_core_pkg::alu_op_t ops[4] = '{alu_core_pkg::add_accum_file_op,
    alu_core_pkg::add_literal_op, alu_core_pkg::literal_minus_accum_op,
    alu_core_pkg::file_minus_accum_op};
  alu_core_pkg::addr_mode_t ms[5] = '{alu_core_pkg::pointer_after_increment,
    alu_core_pkg::pointer_after_decrement,
    alu_core_pkg::pointer_before_increment,
    alu_core_pkg::pointer_plus_accumulator,
    alu_core_pkg::indirect_operand_alias};
  logic [11:0] wa[5] = '{12'h0FF, 12'h100, 12'h100, 12'h0FE, 12'h100};
  logic [11:0] pv[5] = '{12'h100, 12'h0FF, 12'h100, 12'h100, 12'h100};
  assign hready = hreadyout;
  alu_core i_alu_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .exec_valid(exec_valid),
    .exec_op(exec_op), .exec_mode(exec_mode), .ptr_sel(ptr_sel),
    .file_addr(file_addr), .access_sel(access_sel), .dest_sel(dest_sel),
    .literal(literal), .bit_sel(bit_sel), .full_src_addr(full_src_addr),
    .full_dst_addr(full_dst_addr), .prog_target(prog_target),
    .extended_isa_enable(extended_isa_enable), .data_addr(data_addr),
    .file_data_in(file_data_in), .wb_valid(wb_valid), .wb_addr(wb_addr),
    .wb_data(wb_data), .jump_valid(jump_valid), .jump_target(jump_target),
    .accum_out(accum_out), .flags_out(flags_out));
  initial forever #12.5 hclk = ~hclk;
  // ==========================================================
  // Helpers
  function automatic logic [7:0] lf();
    sr = {sr[6:0], sr[7] ^ sr[5] ^ sr[4] ^ sr[3]};
    return sr;
  endfunction : lf
  // Returns {N, OV, Z, HC, C, result}
  function automatic logic [12:0] arith(input logic [7:0] x, y,
      input logic c);
    logic [8:0] s;
    logic [4:0] h;
    s = x + y + c;
    h = x[3:0] + y[3:0] + c;
    return {s[7], x[7] == y[7] && s[7] != x[7], s[7:0] == 8'h00, h[4],
      s[8], s[7:0]};
  endfunction : arith
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, '0);
  endtask : rd
  task automatic ex(input logic [3:0] op, input logic [2:0] md,
      input logic a, input logic [7:0] f, input logic d,
      input logic [7:0] fd);
    @(posedge hclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_mode <= md;
    access_sel <= a;
    file_addr <= f;
    dest_sel <= d;
    literal <= fd;
    file_data_in <= fd;
    @(posedge hclk);
    exec_valid <= 1'b0;
  endtask : ex
  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ==========================================================
  // Monitor: results come in issue order
  always @(posedge hclk) begin
    if (rd_dp) `CHK(hrdata, exp_rd.pop_front())
    if (rd_dp) `CHK(hresp, 1'b0)
    if (wb_valid) `CHK({wb_addr, wb_data},
      exp_wb.size() ? exp_wb.pop_front() : 20'hX)
    if (jump_valid) `CHK(jump_target, exp_j.pop_front())
    rd_dp = hresetn && hsel && htrans[1] && !hwrite && hready;
  end
  // Whole run is a few hundred cycles; fifteen times that is a hang
  initial begin
    repeat (5000) @(posedge hclk);
    errors++;
    summarize();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), '0);
    bus(1'b1, alu_core_pkg::OFS_FLAGS, 32'hFFFF_FFFF);
    rd(alu_core_pkg::OFS_FLAGS, 32'h1F);
    for (int i = 0; i < 16; i++) begin
      a0 = lf();
      b0 = lf();
      if (i == 0) {a0, b0} = 16'h7F01;
      if (i == 2) b0 = a0;
      r = arith(b0, i[1] ? ~a0 : a0, i[1]);
      bus(1'b1, alu_core_pkg::OFS_ACCUM, {24'h0, a0});
      ex(ops[i % 4], alu_core_pkg::direct_mode, 1'b1, 8'h10, 1'b0, b0);
      rd(alu_core_pkg::OFS_ACCUM, r[7:0]);
      rd(alu_core_pkg::OFS_FLAGS, r[12:8]);
    end
    bus(1'b1, alu_core_pkg::OFS_BANK, 32'h3);
    bus(1'b1, alu_core_pkg::OFS_ACCUM, 32'h70);
    exp_wb.push_back({12'h345, 8'h05});
    ex(alu_core_pkg::add_accum_file_op, 3'h0, 1'b1, 8'h45, 1'b1, 8'h95);
    rd(alu_core_pkg::OFS_ACCUM, 32'h70);
    rd(alu_core_pkg::OFS_FLAGS, 32'h01);
    bit_sel <= 3'h3;
    exp_wb.push_back({12'hF80, 8'h08});
    ex(alu_core_pkg::bit_set_op, 3'h0, 1'b0, 8'h80, 1'b0, 8'h00);
    exp_wb.push_back({12'h020, 8'h08});
    ex(alu_core_pkg::bit_set_op, 3'h0, 1'b0, 8'h20, 1'b0, 8'h00);
    extended_isa_enable <= 1'b1;
    bus(1'b1, alu_core_pkg::OFS_PTR2, 32'h100);
    bus(1'b1, alu_core_pkg::OFS_MODE, 32'h0);
    rd(alu_core_pkg::OFS_MODE, 32'h1);
    exp_wb.push_back({12'h120, 8'h08});
    ex(alu_core_pkg::bit_set_op, 3'h0, 1'b0, 8'h20, 1'b0, 8'h00);
    exp_wb.push_back({12'h320, 8'h08});
    ex(alu_core_pkg::bit_set_op, 3'h0, 1'b1, 8'h20, 1'b0, 8'h00);
    bus(1'b1, alu_core_pkg::OFS_FLAGS, 32'h13);
    ex(alu_core_pkg::register_clear_op, 3'h0, 1'b0, 8'hD8, 1'b0, 8'h00);
    rd(alu_core_pkg::OFS_FLAGS, 32'h17);
    bit_sel <= 3'h4;
    ex(alu_core_pkg::bit_clear_op, 3'h0, 1'b0, 8'hD8, 1'b0, 8'h00);
    rd(alu_core_pkg::OFS_FLAGS, 32'h07);
    bus(1'b1, alu_core_pkg::OFS_FLAGS, 32'h09);
    ex(alu_core_pkg::rotate_left_op, 3'h0, 1'b1, 8'h10, 1'b0, 8'h88);
    rd(alu_core_pkg::OFS_ACCUM, 32'h11);
    rd(alu_core_pkg::OFS_FLAGS, 32'h0B);
    bus(1'b1, alu_core_pkg::OFS_FLAGS, 32'h08);
    ex(alu_core_pkg::rotate_right_op, 3'h0, 1'b1, 8'h10, 1'b0, 8'h11);
    rd(alu_core_pkg::OFS_ACCUM, 32'h08);
    rd(alu_core_pkg::OFS_FLAGS, 32'h0B);
    bus(1'b1, alu_core_pkg::OFS_PTR0, 32'hFFFF);
    rd(alu_core_pkg::OFS_PTR0, 32'hFFF);
    bus(1'b1, alu_core_pkg::OFS_PTR0, 32'h0FF);
    bus(1'b1, alu_core_pkg::OFS_ACCUM, 32'hFE);
    bit_sel <= 3'h0;
    for (int i = 0; i < 5; i++) begin
      exp_wb.push_back({wa[i], 8'h01});
      ex(alu_core_pkg::bit_set_op, ms[i], 1'b1, 8'h00, 1'b0, 8'h00);
      rd(alu_core_pkg::OFS_PTR0, pv[i]);
    end
    rd(alu_core_pkg::OFS_FLAGS, 32'h0B);
    full_src_addr <= 12'h123;
    full_dst_addr <= 12'h456;
    exp_wb.push_back({12'h456, 8'h5A});
    ex(alu_core_pkg::file_to_file_move_op, 3'h0, 1'b1, 8'h00, 1'b0, 8'h5A);
    t = {lf(), lf(), lf()};
    prog_target <= t[19:0];
    exp_j.push_back(t[19:0]);
    ex(alu_core_pkg::jump_op, 3'h0, 1'b1, 8'h00, 1'b0, 8'h00);
    repeat (3) @(posedge hclk);
    `CHK(exp_wb.size() + exp_j.size() + exp_rd.size(), 0)
    summarize();
  end
endmodule : test_alu_core

`default_nettype wire
